// ---- shared/iolc_defines.svh ----
// iolc_defines.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name; 32-bit apb data, byte addresses
`ifndef IOLC_DEFINES_SVH
`define IOLC_DEFINES_SVH

`define IOLC_NUM_LINES 6
`define IOLC_OFS_SELECT 12'h000
`define IOLC_OFS_FORMAT 12'h004
`define IOLC_OFS_DIRECTION 12'h008
`define IOLC_OFS_THRESHOLD 12'h00C
`define IOLC_OFS_LEVEL 12'h010
`define IOLC_OFS_INVERT 12'h014
`define IOLC_OFS_FILTER 12'h018
`define IOLC_OFS_TERM 12'h01C
`define IOLC_SEL_W 3
`define IOLC_FILTER_W 16
`define IOLC_RST_SELECT 3'h0
`define IOLC_RST_THRESHOLD 2'h0
`define IOLC_RST_INVERT 1'b0
`define IOLC_RST_TERM 1'b0
// glitch filter unit: 1 us, counted in 100 MHz cycles
`define IOLC_CLK_MHZ 100
`define IOLC_FILTER_UNIT_NS 1000
`define IOLC_FILTER_UNIT_CYC ((`IOLC_FILTER_UNIT_NS * `IOLC_CLK_MHZ) / 1000)
`define IOLC_RST_FILTER 16'h000A

`endif

// ---- shared/iolc_pkg.sv ----
// iolc_pkg.sv: types of the io line conditioning block
// assumes: iolc_defines.svh is compiled alongside
package iolc_pkg;
    typedef enum logic [1:0] {IOLC_FMT_SINGLE_ENDED, IOLC_FMT_OPEN_DRAIN_STYLE, IOLC_FMT_RS422} iolc_format_t;
    typedef enum logic {IOLC_DIR_INPUT, IOLC_DIR_OUTPUT} iolc_dir_t;
    typedef enum logic [1:0] {IOLC_THR_3V3, IOLC_THR_5V, IOLC_THR_12V, IOLC_THR_24V} iolc_thresh_t;
endpackage : iolc_pkg

// ---- hw/iolc_glitch_filter.sv ----
// iolc_glitch_filter.sv: one input line, synchroniser then stability filter
// assumes: raw pin asynchronous to mclk; period counted in filter units
`include "iolc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module iolc_glitch_filter
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic pin_raw,
    input wire logic [`IOLC_FILTER_W-1:0] period,
    input wire logic unit_tick,
    output logic level_clean
);
    logic [2:0] sync_r;
    logic level_r;
    // one bit wider than the period so the largest period stays reachable
    logic [`IOLC_FILTER_W:0] stable_r;
    logic [`IOLC_FILTER_W:0] stable_nxt;
    wire logic agree = (sync_r[1] == sync_r[2]);
    wire logic differs = agree && (sync_r[2] != level_r);
    // first tick may land anywhere in a unit, so a period of n needs n+1 ticks
    wire logic accept = differs && ((period == '0) || (stable_r > {1'b0, period}));

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            sync_r <= 3'h0;
        else
            sync_r <= {sync_r[1:0], pin_raw};
    end

    // count stable time in units; any disagreement restarts it
    always_comb
    begin
        if (!differs)
            stable_nxt = '0;
        else if (unit_tick && stable_r != '1)
            stable_nxt = stable_r + 1'b1;
        else
            stable_nxt = stable_r;
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            stable_r <= '0;
            level_r <= 1'b0;
        end
        else
        begin
            stable_r <= accept ? '0 : stable_nxt;
            if (accept)
                level_r <= sync_r[2];
        end
    end

    assign level_clean = level_r;

    AST_NO_EARLY_CHANGE: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(level_r) |-> ($past(period) == '0) || ($past(stable_r) > $past(period)))
        else $error("filtered level changed before the period elapsed");
endmodule : iolc_glitch_filter
`default_nettype wire

// ---- hw/iolc_top.sv ----
// iolc_top.sv: per-line conditioning of six io lines, apb register slave
// assumes: apb master on mclk; line formats and directions are board straps
`include "iolc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - selector picks one of six lines
// - read-only electrical format of selected line
// - read-only direction; writes have no effect
// - four-way input threshold drives receiver control
// - read-only live level of selected line
// - per-line inversion flips signal polarity
// - accept new input level after stable period
// - per-line termination drives termination enable
module iolc_top
#(
    parameter logic [11:0] LINE_FORMATS = {6{2'b00}},
    parameter logic [5:0] LINE_DIRS = 6'b11_0000
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] line_in,
    input wire logic [5:0] out_drive,
    output logic [5:0] line_out,
    output logic [11:0] threshold_ctrl,
    output logic [5:0] termination_en
);
    localparam int NL = `IOLC_NUM_LINES;

    // -------------------------------------------------
    // configuration state
    // -------------------------------------------------
    logic [`IOLC_SEL_W-1:0] io_index_select_r;
    logic [1:0] thresh_r [NL];
    logic [NL-1:0] invert_r;
    logic [NL-1:0] term_r;
    logic [`IOLC_FILTER_W-1:0] filter_r [NL];
    logic [NL-1:0] line_out_r;
    logic [11:0] thr_out_r;
    logic [NL-1:0] term_out_r;
    logic [31:0] prdata_r;
    logic [6:0] unit_cnt_r;
    logic [NL-1:0] clean;
    logic [NL-1:0] level_report;

    // -------------------------------------------------
    // apb decode
    // -------------------------------------------------
    wire logic access = psel && penable;
    wire logic wr = access && pwrite && pstrb[0];
    wire logic hit_sel = (paddr == `IOLC_OFS_SELECT);
    wire logic hit_fmt = (paddr == `IOLC_OFS_FORMAT);
    wire logic hit_dir = (paddr == `IOLC_OFS_DIRECTION);
    wire logic hit_thr = (paddr == `IOLC_OFS_THRESHOLD);
    wire logic hit_lvl = (paddr == `IOLC_OFS_LEVEL);
    wire logic hit_inv = (paddr == `IOLC_OFS_INVERT);
    wire logic hit_flt = (paddr == `IOLC_OFS_FILTER);
    wire logic hit_trm = (paddr == `IOLC_OFS_TERM);
    wire logic mapped = hit_sel | hit_fmt | hit_dir | hit_thr | hit_lvl | hit_inv | hit_flt | hit_trm;
    wire logic sel_ok = (pwdata[`IOLC_SEL_W-1:0] < 3'(NL));
    wire logic [2:0] cur = io_index_select_r;
    wire logic unit_tick = (unit_cnt_r == 7'(`IOLC_FILTER_UNIT_CYC - 1));

    assign pready = 1'b1;
    // unmapped address or out-of-range selector answers with an error
    assign pslverr = access && (!mapped || (pwrite && hit_sel && !sel_ok));

    // -------------------------------------------------
    // selector and per-line settings
    // -------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            io_index_select_r <= `IOLC_RST_SELECT;
        else if (wr && hit_sel && sel_ok)
            io_index_select_r <= pwdata[`IOLC_SEL_W-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            unit_cnt_r <= 7'h00;
        else
            unit_cnt_r <= unit_tick ? 7'h00 : unit_cnt_r + 7'h01;
    end

    genvar g;
    generate
        for (g = 0; g < NL; g++)
        begin : g_line
            wire logic me = (cur == 3'(g));
            wire logic is_in = (LINE_DIRS[g] == iolc_pkg::IOLC_DIR_INPUT);

            always_ff @(posedge mclk)
            begin
                if (!rstn)
                begin
                    thresh_r[g] <= `IOLC_RST_THRESHOLD;
                    invert_r[g] <= `IOLC_RST_INVERT;
                    term_r[g] <= `IOLC_RST_TERM;
                    filter_r[g] <= `IOLC_RST_FILTER;
                end
                else if (wr && me)
                begin
                    if (hit_thr && is_in)
                        thresh_r[g] <= pwdata[1:0];
                    if (hit_inv)
                        invert_r[g] <= pwdata[0];
                    if (hit_trm)
                        term_r[g] <= pwdata[0];
                    if (hit_flt && is_in)
                        filter_r[g] <= pwdata[`IOLC_FILTER_W-1:0];
                end
            end

            iolc_glitch_filter u_filt
            (
                .mclk(mclk),
                .rstn(rstn),
                .pin_raw(line_in[g]),
                .period(filter_r[g]),
                .unit_tick(unit_tick),
                .level_clean(clean[g])
            );

            // inputs report filtered then inverted; outputs report the driven pin
            assign level_report[g] = is_in ? (clean[g] ^ invert_r[g]) : line_out_r[g];
        end
    endgenerate

    // -------------------------------------------------
    // pin-facing outputs
    // -------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            line_out_r <= '0;
            thr_out_r <= 12'h000;
            term_out_r <= '0;
        end
        else
        begin
            line_out_r <= (out_drive ^ invert_r) & LINE_DIRS;
            for (int i = 0; i < NL; i++)
                thr_out_r[2*i +: 2] <= thresh_r[i];
            term_out_r <= term_r;
        end
    end

    assign line_out = line_out_r;
    assign threshold_ctrl = thr_out_r;
    assign termination_en = term_out_r;

    // -------------------------------------------------
    // read data
    // -------------------------------------------------
    wire logic [31:0] rd_sel = {29'h0, io_index_select_r};
    wire logic [31:0] rd_fmt = {30'h0, LINE_FORMATS[2*cur +: 2]};
    wire logic [31:0] rd_dir = {31'h0, LINE_DIRS[cur]};
    wire logic [31:0] rd_thr = {30'h0, thresh_r[cur]};
    wire logic [31:0] rd_lvl = {31'h0, level_report[cur]};
    wire logic [31:0] rd_inv = {31'h0, invert_r[cur]};
    wire logic [31:0] rd_flt = {16'h0, filter_r[cur]};
    wire logic [31:0] rd_trm = {31'h0, term_r[cur]};
    wire logic [31:0] rd_mux =
        hit_sel ? rd_sel : hit_fmt ? rd_fmt : hit_dir ? rd_dir : hit_thr ? rd_thr :
        hit_lvl ? rd_lvl : hit_inv ? rd_inv : hit_flt ? rd_flt : hit_trm ? rd_trm : 32'h0000_0000;

    // registered read data lags one cycle; the setup cycle fills it in time
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            prdata_r <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata_r <= rd_mux;
    end

    assign prdata = prdata_r;

    // -------------------------------------------------
    // checks
    // -------------------------------------------------
    // named bus steps; multi-step checks are built from them
    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence

    sequence s_sel_taken;
        wr && hit_sel && sel_ok;
    endsequence

    sequence s_sel_refused;
        wr && hit_sel && !sel_ok;
    endsequence

    sequence s_term_taken;
        wr && hit_trm;
    endsequence

    // output lines ignore threshold and filter period writes and keep their reset values
    sequence s_wr_out_line;
        wr && LINE_DIRS[cur];
    endsequence

    sequence s_wr_in_line;
        wr && !LINE_DIRS[cur];
    endsequence

    // selector
    AST_SEL_RANGE: assert property (@(posedge mclk) disable iff (!rstn)
        io_index_select_r < 3'(NL))
        else $error("line selector out of range");

    AST_SEL_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        s_sel_taken |=> io_index_select_r == $past(pwdata[2:0]))
        else $error("selector write not taken");

    AST_SEL_REFUSE: assert property (@(posedge mclk) disable iff (!rstn)
        s_sel_refused |-> pslverr ##1 $stable(io_index_select_r))
        else $error("bad selector not refused");

    // bus reads
    AST_DIR_RO: assert property (@(posedge mclk) disable iff (!rstn)
        access && hit_dir |-> !pslverr)
        else $error("direction access errored");

    AST_DIR_READ: assert property (@(posedge mclk) disable iff (!rstn)
        s_rd_setup ##0 hit_dir |=> prdata == {31'h0, LINE_DIRS[$past(cur)]})
        else $error("direction read wrong");

    AST_LVL_READ: assert property (@(posedge mclk) disable iff (!rstn)
        s_rd_setup ##0 hit_lvl |=> prdata == {31'h0, $past(level_report[cur])})
        else $error("level read wrong");

    AST_FMT_READ: assert property (@(posedge mclk) disable iff (!rstn)
        s_rd_setup ##0 hit_fmt |=> prdata[31:2] == 30'h0)
        else $error("format read has high bits");

    // read data must not move between read setups
    AST_RD_STANDS: assert property (@(posedge mclk) disable iff (!rstn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved outside a read setup");

    // line settings and pin-facing outputs
    AST_TERM_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        s_term_taken |=> term_r[$past(cur)] == $past(pwdata[0]))
        else $error("termination write not taken");

    AST_TERM_FOLLOW: assert property (@(posedge mclk) disable iff (!rstn)
        s_term_taken |=> ##1 termination_en[$past(cur, 2)] == $past(pwdata[0], 2))
        else $error("termination output does not follow control");

    AST_INV_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        wr && hit_inv |=> invert_r[$past(cur)] == $past(pwdata[0]))
        else $error("inversion write not taken");

    AST_INV_OUT: assert property (@(posedge mclk) disable iff (!rstn)
        LINE_DIRS[cur] |=> line_out[$past(cur)] == ($past(out_drive[cur]) ^ $past(invert_r[cur])))
        else $error("output polarity wrong");

    AST_THR_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        s_wr_in_line ##0 hit_thr |=> thresh_r[$past(cur)] == $past(pwdata[1:0]))
        else $error("threshold write not taken");

    AST_THR_LOCKED: assert property (@(posedge mclk) disable iff (!rstn)
        s_wr_out_line ##0 hit_thr |=> thresh_r[$past(cur)] == $past(thresh_r[cur]))
        else $error("output line threshold changed");

    AST_THR_FOLLOW: assert property (@(posedge mclk) disable iff (!rstn)
        1'b1 |=> threshold_ctrl[2*$past(cur) +: 2] == $past(thresh_r[cur]))
        else $error("threshold control mismatch");

    AST_FLT_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        s_wr_in_line ##0 hit_flt |=> filter_r[$past(cur)] == $past(pwdata[`IOLC_FILTER_W-1:0]))
        else $error("filter period write not taken");

    AST_FLT_LOCKED: assert property (@(posedge mclk) disable iff (!rstn)
        s_wr_out_line ##0 hit_flt |=> filter_r[$past(cur)] == $past(filter_r[cur]))
        else $error("output line filter period changed");

    AST_IN_REPORT: assert property (@(posedge mclk) disable iff (!rstn)
        !LINE_DIRS[cur] |-> level_report[cur] == (clean[cur] ^ invert_r[cur]))
        else $error("input report not filtered and inverted");

    AST_IN_NOT_DRIVEN: assert property (@(posedge mclk) disable iff (!rstn)
        (line_out & ~LINE_DIRS) == 6'h00)
        else $error("input line driven");
endmodule : iolc_top
`default_nettype wire

// ---- bench/iolc_line_model.sv ----
// iolc_line_model.sv: outside sources driving the six raw line pins
// assumes: bench sets wanted levels; glitch flips every pin while high
`timescale 1ns/1ps
`default_nettype none

module iolc_line_model
(
    input wire logic mclk,
    input wire logic [5:0] want,
    input wire logic glitch,
    output logic [5:0] pins
);
    // pins move just after the edge, as a field sensor would
    always @(posedge mclk)
    begin
        pins <= want ^ {6{glitch}};
    end
endmodule : iolc_line_model
`default_nettype wire

// ---- bench/io_line_conditioning_bench.sv ----
// io_line_conditioning_bench.sv: self-checking bench of iolc_top
// assumes: iolc_defines.svh and iolc_pkg compiled first; one 100 MHz clock
`include "iolc_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module io_line_conditioning_bench;
    localparam logic [11:0] FMTS = 12'h892;
    localparam logic [5:0] DIRS = 6'h30;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [5:0] out_drive = 6'h00;
    logic [5:0] want = 6'h00;
    logic glitch = 1'b0;
    logic [31:0] prdata, rdat, r;
    logic pready, pslverr, rerr;
    logic [5:0] line_in, line_out, termination_en;
    logic [11:0] threshold_ctrl;
    logic [31:0] seed = 32'h0000_14C8;
    int n_errors = 0;
    int total_checks = 0;
    int i;

    always #5 mclk = ~mclk;

    iolc_top #(.LINE_FORMATS(FMTS), .LINE_DIRS(DIRS)) iolc_top_inst (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .line_in(line_in), .out_drive(out_drive), .line_out(line_out),
        .threshold_ctrl(threshold_ctrl), .termination_en(termination_en));
    iolc_line_model iolc_line_model_inst (.mclk(mclk), .want(want), .glitch(glitch), .pins(line_in));

    // ------------------------------------------------------------
    // expectations and bus tasks
    // ------------------------------------------------------------
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // output lines keep no threshold
    function automatic logic [1:0] exp_thr(input int k, input logic [1:0] t);
        return DIRS[k] ? 2'h0 : t;
    endfunction : exp_thr

    function automatic logic exp_out(input logic d, input logic inv);
        return d ^ inv;
    endfunction : exp_out

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge mclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            // wait for the answer; only the watchdog ends a hang
            do
                @(posedge mclk);
            while (pready !== 1'b1);
            rdat = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        for (i = 0; i < 6; i++)
        begin
            r = xs();
            wr(`IOLC_OFS_SELECT, i);
            rd(`IOLC_OFS_FORMAT);
            chk("format", (FMTS >> (2 * i)) & 12'h003, rdat);
            chk("format_err", 0, rerr);
            wr(`IOLC_OFS_DIRECTION, ~DIRS[i]);
            rd(`IOLC_OFS_DIRECTION);
            chk("direction", DIRS[i], rdat);
            rd(`IOLC_OFS_TERM);
            chk("term_reset", 0, rdat);
            rd(`IOLC_OFS_FILTER);
            chk("filter_reset", `IOLC_RST_FILTER, rdat);
            wr(`IOLC_OFS_THRESHOLD, i % 4);
            wr(`IOLC_OFS_TERM, r[0]);
            repeat (2) @(posedge mclk);
            chk("threshold", exp_thr(i, i % 4), threshold_ctrl[2*i+:2]);
            rd(`IOLC_OFS_THRESHOLD);
            chk("thr_read", exp_thr(i, i % 4), rdat);
            chk("term_pin", r[0], termination_en[i]);
            rd(`IOLC_OFS_TERM);
            chk("term_read", r[0], rdat);
        end
        for (i = 4; i < 6; i++)
        begin
            r = xs();
            wr(`IOLC_OFS_SELECT, i);
            wr(`IOLC_OFS_INVERT, r[0]);
            out_drive <= r[13:8];
            repeat (3) @(posedge mclk);
            chk("line_out", exp_out(r[8+i], r[0]), line_out[i]);
            chk("line_out_in", 0, line_out[3:0]);
            wr(`IOLC_OFS_FILTER, r[31:16]);
            rd(`IOLC_OFS_FILTER);
            chk("flt_locked", `IOLC_RST_FILTER, rdat);
            rd(`IOLC_OFS_LEVEL);
            chk("level_out", exp_out(r[8+i], r[0]), rdat);
        end
        wr(`IOLC_OFS_SELECT, 6);
        chk("sel_refused", 1, rerr);
        rd(`IOLC_OFS_SELECT);
        chk("sel_kept", 5, rdat);
        rd(12'h040);
        chk("unmapped_err", 1, rerr);
        chk("unmapped_data", 0, rdat);
        // period 3 units needs 300+ stable cycles, so a 50-cycle glitch must die
        wr(`IOLC_OFS_SELECT, 0);
        wr(`IOLC_OFS_FILTER, 3);
        rd(`IOLC_OFS_FILTER);
        chk("flt_read", 3, rdat);
        repeat (500) @(posedge mclk);
        rd(`IOLC_OFS_LEVEL);
        chk("in_low", 0, rdat);
        want <= 6'h01;
        repeat (60) @(posedge mclk);
        rd(`IOLC_OFS_LEVEL);
        chk("in_early", 0, rdat);
        repeat (500) @(posedge mclk);
        rd(`IOLC_OFS_LEVEL);
        chk("in_high", 1, rdat);
        glitch <= 1'b1;
        repeat (50) @(posedge mclk);
        glitch <= 1'b0;
        repeat (20) @(posedge mclk);
        rd(`IOLC_OFS_LEVEL);
        chk("glitch", 1, rdat);
        wr(`IOLC_OFS_INVERT, 1);
        repeat (2) @(posedge mclk);
        rd(`IOLC_OFS_LEVEL);
        chk("in_invert", 0, rdat);
        summarize();
    end

    // whole run is near 1400 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        summarize();
    end
endmodule : io_line_conditioning_bench
`default_nettype wire
